// ---- src/isa_top.sv ----
// Connector input pin assignment with an APB register slave.
// Assumes pins are synchronous to clk_sys_in and active high.
`timescale 1ns/10ps
`default_nettype none
module isa_top
  import isa_pkg::*;
(
  input  wire logic                clk_sys_in,
  input  wire logic                arst_n_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [ADDR_W-1:0]   paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_FUNC-1:0]      func_out,
  output logic                     forward_stroke_limit_out,
  output logic                     reverse_stroke_limit_out,
  output logic                     control_change_input_out
);

  logic [NUM_SEL-1:0][SEL_W-1:0] sel;
  logic [SEL_W-1:0]              bank_rd;
  logic [1:0]                    misc;
  logic [NUM_PINS-1:0]           pin_q;
  logic                          setup;
  logic                          wr_done;
  logic                          hit_bank;
  logic                          hit_misc;
  logic                          hit_stat;
  logic                          rd_is_bank;
  logic [31:0]                   rd_aux;
  logic [31:0]                   status;
  logic                          speed_mode;
  logic                          cc_pin3;
  logic [3:0]                    fwd_sel;
  logic [3:0]                    rev_sel;
  logic                          rev_dis;
  logic [15:0]                   valid_mask;
  logic [NUM_PINS-1:0][3:0]      code;
  logic [NUM_PINS-1:0]           gen_has;
  logic [NUM_PINS-1:0]           fwd_keep;
  logic [NUM_PINS-1:0]           rev_keep;
  logic [NUM_PINS-1:0]           gen_en;
  logic [NUM_FUNC-1:0]           next_func;
  logic                          next_fwd;
  logic                          next_rev;
  logic                          next_cc;

  // APB decode; the slave always answers with no wait state.
  assign setup      = psel_in && !penable_in;
  assign wr_done    = psel_in && penable_in && pwrite_in;
  assign pready_out = 1'b1;
  assign hit_bank   = paddr_in[1:0] == 2'h0 && paddr_in <= OFS_STROKE_SEL;
  assign hit_misc   = paddr_in == OFS_MISC;
  assign hit_stat   = paddr_in == OFS_STATUS;

  isa_selbank u_bank (
    .clk_sys_in  (clk_sys_in),
    .arst_n_in   (arst_n_in),
    .wr_en_in    (wr_done && hit_bank),
    .wr_idx_in   (paddr_in[4:2]),
    .wr_data_in  (pwdata_in[SEL_W-1:0]),
    .rd_idx_in   (paddr_in[4:2]),
    .rd_data_out (bank_rd),
    .sel_out     (sel)
  );

  // Misc register: control-change placement and control mode.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      misc <= MISC_RESET;
    end else if (wr_done && hit_misc) begin
      misc <= pwdata_in[1:0];
    end
  end

  // Read source and error flag are caught in the setup cycle.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_is_bank  <= 1'b0;
      rd_aux      <= '0;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      rd_is_bank  <= hit_bank;
      rd_aux      <= hit_misc ? {30'h0, misc} :
                     hit_stat ? status : 32'h0;
      pslverr_out <= !(hit_bank || hit_misc || (hit_stat && !pwrite_in));
    end
  end

  assign prdata_out = rd_is_bank ? {16'h0, bank_rd} : rd_aux;

  assign status = {16'h0, 4'h0, gen_en, 1'b0, control_change_input_out,
                   reverse_stroke_limit_out, forward_stroke_limit_out,
                   pin_q};

  // Pin sampling.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_in;
    end
  end

  assign speed_mode = misc[MISC_SPEED];
  assign cc_pin3    = misc[MISC_CC_PIN3];
  assign valid_mask = speed_mode ? VALID_SPD : VALID_POS;
  assign fwd_sel    = sel[IDX_STROKE][FWD_LSB +: 4];
  assign rev_sel    = sel[IDX_STROKE][REV_LSB +: 4];
  assign rev_dis    = fwd_sel == rev_sel;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      assign code[gp] = speed_mode ? sel[gp][SPD_LSB +: 4]
                                   : sel[gp][POS_LSB +: 4];
      assign gen_has[gp] = valid_mask[code[gp]];
      if (gp == P6) begin : g_p6
        assign fwd_keep[gp] = fwd_sel == LIM_PIN6 && !gen_has[gp];
      end else if (gp == P3) begin : g_p3
        assign fwd_keep[gp] = fwd_sel == LIM_PIN3 && !cc_pin3;
      end else begin : g_pf
        assign fwd_keep[gp] = fwd_sel == 4'(gp + 1);
      end
      if (gp == P7) begin : g_p7
        assign rev_keep[gp] = rev_sel == LIM_PIN7 && !rev_dis &&
                              !gen_has[gp];
      end else if (gp == P3) begin : g_r3
        assign rev_keep[gp] = rev_sel == LIM_PIN3 && !rev_dis &&
                              !cc_pin3;
      end else begin : g_pr
        assign rev_keep[gp] = rev_sel == 4'(gp + 1) && !rev_dis;
      end
      if (gp == P3) begin : g_e3
        assign gen_en[gp] = gen_has[gp] && !cc_pin3 &&
                            !fwd_keep[gp] && !rev_keep[gp];
      end else begin : g_en
        assign gen_en[gp] = gen_has[gp] &&
                            !fwd_keep[gp] && !rev_keep[gp];
      end
    end
  endgenerate

  // Function lines gather their pins; nothing routed stays low.
  always_comb begin
    next_func = '0;
    next_fwd  = 1'b0;
    next_rev  = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (gen_en[p] && pin_q[p]) begin
        next_func[code[p]] = 1'b1;
      end
      if (fwd_keep[p] && pin_q[p]) begin
        next_fwd = 1'b1;
      end
      if (rev_keep[p] && pin_q[p]) begin
        next_rev = 1'b1;
      end
    end
    next_cc = cc_pin3 && pin_q[P3];
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      func_out                 <= '0;
      forward_stroke_limit_out <= 1'b0;
      reverse_stroke_limit_out <= 1'b0;
      control_change_input_out <= 1'b0;
    end else begin
      func_out                 <= next_func;
      forward_stroke_limit_out <= next_fwd;
      reverse_stroke_limit_out <= next_rev;
      control_change_input_out <= next_cc;
    end
  end

  // Checks.
  a_unused_codes_low: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    func_out[FN_NONE] == 1'b0 && func_out[4] == 1'b0 &&
    func_out[15] == 1'b0)
    else $error("Unassignable function code went active.");

  a_pin3_routes_func: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (!cc_pin3 && fwd_sel != LIM_PIN3 && rev_sel != LIM_PIN3 &&
     gen_has[P3] && pin_q[P3]) |=> func_out[$past(code[P3])])
    else $error("Pin 3 function not routed.");

  a_cc_blocks_pin3: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    cc_pin3 |-> !gen_en[P3] && !fwd_keep[P3] && !rev_keep[P3])
    else $error("Pin 3 selector used while control change owns pin 3.");

  a_cc_follows_pin: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (cc_pin3 && pin_q[P3]) ##1 cc_pin3 |-> control_change_input_out)
    else $error("Control change input did not follow pin 3.");

  a_limit_blocks_pin3: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (!cc_pin3 && fwd_sel == LIM_PIN3) |-> !gen_en[P3])
    else $error("Pin 3 selector used under a stroke limit.");

  a_pin5_routes_func: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (fwd_sel != LIM_PIN5 && rev_sel != LIM_PIN5 && gen_has[1] &&
     pin_q[1]) |=> func_out[$past(code[1])])
    else $error("Pin 5 function not routed.");

  a_pin6_beats_fwd: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (fwd_sel == LIM_PIN6 && gen_has[P6]) |-> gen_en[P6] &&
    !fwd_keep[P6])
    else $error("Pin 6 selector lost to default forward limit.");

  a_pin7_beats_rev: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rev_sel == LIM_PIN7 && gen_has[P7]) |-> !rev_keep[P7])
    else $error("Pin 7 selector lost to default reverse limit.");

  a_shared_pin_rev: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (fwd_sel == rev_sel)[*2] |-> !reverse_stroke_limit_out)
    else $error("Reverse limit active while sharing the forward pin.");

  a_limit_pin5_wins: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (fwd_sel == LIM_PIN5 && pin_q[1]) |=> forward_stroke_limit_out)
    else $error("Forward limit on pin 5 not routed.");

  a_idle_pins_quiet: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (pin_q == 4'h0 && !cc_pin3) |=> func_out == '0 &&
    !forward_stroke_limit_out && !reverse_stroke_limit_out)
    else $error("Function active with all pins low.");

  a_pin6_routes_func: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rev_sel != LIM_PIN6 && gen_has[P6] && pin_q[P6]) |=>
    func_out[$past(code[P6])])
    else $error("Pin 6 function not routed.");

  a_pin7_routes_func: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (fwd_sel != LIM_PIN7 && gen_has[P7] && pin_q[P7]) |=>
    func_out[$past(code[P7])])
    else $error("Pin 7 function not routed.");

  a_rev_pin5_wins: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rev_sel == LIM_PIN5 && fwd_sel != LIM_PIN5 && pin_q[1]) |=>
    reverse_stroke_limit_out)
    else $error("Reverse limit on pin 5 not routed.");

  a_fwd_pin7_wins: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (fwd_sel == LIM_PIN7 && pin_q[P7]) |=> forward_stroke_limit_out)
    else $error("Forward limit on pin 7 not routed.");

  a_fwd_default_kept: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (fwd_sel == LIM_PIN6 && !gen_has[P6] && pin_q[P6]) |=>
    forward_stroke_limit_out)
    else $error("Default forward limit lost on pin 6.");

  a_rev_default_kept: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rev_sel == LIM_PIN7 && fwd_sel != LIM_PIN7 && !gen_has[P7] &&
     pin_q[P7]) |=> reverse_stroke_limit_out)
    else $error("Default reverse limit lost on pin 7.");

  a_fwd_pin3_wins: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (fwd_sel == LIM_PIN3 && !cc_pin3 && pin_q[P3]) |=>
    forward_stroke_limit_out)
    else $error("Forward limit on pin 3 not routed.");

  a_rev_blocks_pin3: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (!cc_pin3 && rev_sel == LIM_PIN3) |-> !gen_en[P3])
    else $error("Pin 3 selector used under the reverse limit.");

  a_func_needs_route: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (gen_en == 4'h0) |=> func_out == '0)
    else $error("Function active with no general selector in use.");

  a_fwd_needs_route: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (fwd_keep == 4'h0) |=> !forward_stroke_limit_out)
    else $error("Forward limit active with no pin placed.");

  a_rev_needs_route: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rev_keep == 4'h0) |=> !reverse_stroke_limit_out)
    else $error("Reverse limit active with no pin placed.");

  a_cc_needs_select: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    !cc_pin3 |=> !control_change_input_out)
    else $error("Control change active while not placed on pin 3.");

endmodule : isa_top
`default_nettype wire

// ---- inc/isa_pkg.sv ----
// Constants for the connector input pin assignment block.
// Assumes a 32-bit APB master and four synchronous connector input pins.
`default_nettype none
package isa_pkg;

  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned NUM_SEL  = 5;
  localparam int unsigned NUM_FUNC = 16;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned SEL_W    = 16;
  localparam int unsigned IDX_W    = 3;

  // Register byte offsets.
  localparam logic [7:0] OFS_PIN3_SEL   = 8'h00;
  localparam logic [7:0] OFS_PIN5_SEL   = 8'h04;
  localparam logic [7:0] OFS_PIN6_SEL   = 8'h08;
  localparam logic [7:0] OFS_PIN7_SEL   = 8'h0c;
  localparam logic [7:0] OFS_STROKE_SEL = 8'h10;
  localparam logic [7:0] OFS_MISC       = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;

  // Index of the stroke-end selector within the selector bank.
  localparam logic [2:0] IDX_STROKE = 3'h4;

  // Reset values, entry 0 is the pin 3 selector.
  localparam logic [4:0][15:0] SEL_RESET = {
    16'h0403, 16'h0000, 16'h0000, 16'h0995, 16'h0882};
  localparam logic [1:0] MISC_RESET = 2'h0;

  // Selector fields: low digit for position mode, next for speed mode.
  localparam int unsigned POS_LSB = 0;
  localparam int unsigned SPD_LSB = 4;
  // Stroke-end selector fields.
  localparam int unsigned FWD_LSB = 0;
  localparam int unsigned REV_LSB = 8;
  // Misc register fields.
  localparam int unsigned MISC_CC_PIN3 = 0;
  localparam int unsigned MISC_SPEED   = 1;

  // Function codes shared by every pin selector.
  localparam logic [3:0] FN_NONE       = 4'h0;
  localparam logic [3:0] FN_SERVO_ON   = 4'h1;
  localparam logic [3:0] FN_ALARM_CLR  = 4'h2;
  localparam logic [3:0] FN_PROP_CTRL  = 4'h3;
  localparam logic [3:0] FN_CLEAR      = 4'h5;
  localparam logic [3:0] FN_SPEED_1    = 4'h6;
  localparam logic [3:0] FN_SPEED_2    = 4'h7;
  localparam logic [3:0] FN_START_FWD  = 4'h8;
  localparam logic [3:0] FN_START_REV  = 4'h9;
  localparam logic [3:0] FN_SPEED_3    = 4'ha;
  localparam logic [3:0] FN_GEAR_1     = 4'hb;
  localparam logic [3:0] FN_GEAR_2     = 4'hc;
  localparam logic [3:0] FN_TORQUE_LIM = 4'hd;
  localparam logic [3:0] FN_GAIN_CHG   = 4'he;

  // Codes valid in each control mode, one bit per code.
  localparam logic [15:0] VALID_POS = 16'h782e;
  localparam logic [15:0] VALID_SPD = 16'h67ee;

  // Stroke-end pin codes; pin code of pin index p is p + 1.
  localparam logic [3:0] LIM_PIN3 = 4'h1;
  localparam logic [3:0] LIM_PIN5 = 4'h2;
  localparam logic [3:0] LIM_PIN6 = 4'h3;
  localparam logic [3:0] LIM_PIN7 = 4'h4;

  // Pin indices.
  localparam int unsigned P3 = 0;
  localparam int unsigned P6 = 2;
  localparam int unsigned P7 = 3;

endpackage : isa_pkg
`default_nettype wire

// ---- src/isa_selbank.sv ----
// Selector bank: five 16-bit selectors with a registered read port.
// Assumes the caller writes only at the APB completion edge.
`timescale 1ns/10ps
`default_nettype none
module isa_selbank
  import isa_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  wr_en_in,
  input  wire logic [IDX_W-1:0]      wr_idx_in,
  input  wire logic [SEL_W-1:0]      wr_data_in,
  input  wire logic [IDX_W-1:0]      rd_idx_in,
  output logic      [SEL_W-1:0]      rd_data_out,
  output logic [NUM_SEL-1:0][SEL_W-1:0] sel_out
);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SEL; gi++) begin : g_ent
      always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sel_out[gi] <= SEL_RESET[gi];
        end else if (wr_en_in && wr_idx_in == IDX_W'(gi)) begin
          sel_out[gi] <= wr_data_in;
        end
      end
    end
  endgenerate

  // Read data always come from a register.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= '0;
    end else if (rd_idx_in < IDX_W'(NUM_SEL)) begin
      rd_data_out <= sel_out[rd_idx_in];
    end else begin
      rd_data_out <= '0;
    end
  end

endmodule : isa_selbank
`default_nettype wire

// ---- verif/isa_pin_model.sv ----
// Model of the external controller that drives the connector input pins.
// Assumes the bench hands it the wanted levels one clock ahead.
`timescale 1ns/10ps
`default_nettype none
module isa_pin_model (
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  input  wire logic [3:0] level_in,
  output logic      [3:0] pin_out
);
  // Pins change just after a rising edge, as a controller output would.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_out <= 4'h0;
    end else begin
      pin_out <= level_in;
    end
  end
endmodule : isa_pin_model
`default_nettype wire

// ---- verif/test_input_pin_signal_assignment.sv ----
// Self-checking bench for the connector input pin assignment block.
// Assumes the package, the design files and the pin model compile first.
`timescale 1ns/10ps
`default_nettype none
module test_input_pin_signal_assignment;
  import isa_pkg::*;
  localparam logic [15:0] RST [5] = '{16'h0882, 16'h0995, 16'h0000,
                                      16'h0000, 16'h0403};
  localparam logic [15:0] LIM [10] = '{16'h0403, 16'h0101, 16'h0201,
    16'h0302, 16'h0304, 16'h0104, 16'h0303, 16'h0404, 16'h0000, 16'h0204};
  logic        clk_sys_in = 1'b0;
  logic        arst_n_in  = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [3:0]  lvl_drv    = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pin;
  logic [15:0] func;
  logic        fwd;
  logic        rev;
  logic        cc;
  logic [15:0] sel [5];
  logic [1:0]  misc;
  logic [3:0]  level;
  logic [31:0] rd;
  logic        err;
  logic [31:0] ex;
  int          error_cnt = 0;
  int          n_checks  = 0;
  int          cyc       = 0;
  int          seed      = 49392;

  always #25 clk_sys_in = ~clk_sys_in;

  isa_pin_model i_pins (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .level_in(lvl_drv), .pin_out(pin));

  isa_top i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pin_in(pin),
    .func_out(func), .forward_stroke_limit_out(fwd),
    .reverse_stroke_limit_out(rev), .control_change_input_out(cc));

  function automatic logic [3:0] code(int p);
    return misc[1] ? sel[p][7:4] : sel[p][3:0];
  endfunction : code

  function automatic logic vld(int p);
    logic [15:0] m = misc[1] ? VALID_SPD : VALID_POS;
    return m[code(p)];
  endfunction : vld

  function automatic logic [31:0] expect_out();
    logic [15:0] f   = 16'h0;
    logic        fw  = 1'b0;
    logic        rv  = 1'b0;
    logic        c   = 1'b0;
    logic [3:0]  own = 4'h0;
    logic [3:0]  fc  = sel[4][3:0];
    logic [3:0]  rc  = sel[4][11:8];
    if (misc[0]) begin
      c = level[0];
      own[0] = 1'b1;
    end
    if (fc inside {[1:4]} && !own[fc-1] && !(fc == 4'h3 && vld(2))) begin
      fw = level[fc-1];
      own[fc-1] = 1'b1;
    end
    if (rc inside {[1:4]} && rc != fc && !own[rc-1] &&
        !(rc == 4'h4 && vld(3))) begin
      rv = level[rc-1];
      own[rc-1] = 1'b1;
    end
    for (int p = 0; p < 4; p++) begin
      if (!own[p] && vld(p)) f[code(p)] |= level[p];
    end
    return {13'h0, c, rv, fw, f};
  endfunction : expect_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic apply();
    for (int i = 0; i < 5; i++) apb(1'b1, 8'(4 * i), {16'hdead, sel[i]});
    apb(1'b1, OFS_MISC, {30'h0, misc});
    @(posedge clk_sys_in);
    lvl_drv <= level;
    repeat (4) @(posedge clk_sys_in);
  endtask : apply

  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    misc = 2'h0;
    for (int i = 0; i < 5; i++) begin
      sel[i] = RST[i];
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, {16'h0, RST[i]});
    end
    apb(1'b0, OFS_MISC, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      level = 4'($random(seed));
      apply();
      check({13'h0, cc, rev, fwd, func}, expect_out());
    end
    apb(1'b1, OFS_STATUS, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    check({31'h0, err}, 32'h1);
    sel[4] = 16'h0000;
    for (int m = 0; m < 32; m++) begin
      misc = {m[4], 1'b0};
      for (int p = 0; p < 4; p++) sel[p] = {8'h00, {2{4'(m + p)}}};
      level = m[0] ? 4'hf : 4'($random(seed));
      apply();
      check({13'h0, cc, rev, fwd, func}, expect_out());
    end
    for (int j = 0; j < 160; j++) begin
      sel[4] = (j < 60) ? LIM[j % 10] :
               {4'h0, 4'($unsigned($random(seed)) % 5),
                4'h0, 4'($unsigned($random(seed)) % 5)};
      for (int p = 0; p < 4; p++) sel[p] = 16'($random(seed)) & 16'h00ff;
      misc = 2'($random(seed));
      level = 4'($random(seed));
      apply();
      check({13'h0, cc, rev, fwd, func}, expect_out());
      check({13'h0, cc, rev, fwd, func}, expect_out());
    end
    apb(1'b0, OFS_MISC, 32'h0);
    check(rd, {30'h0, misc});
    apb(1'b0, OFS_STATUS, 32'h0);
    ex = expect_out();
    check({31'h0, err}, 32'h0);
    check({25'h0, rd[6:0]}, {25'h0, ex[18:16], level});
    apb(1'b0, OFS_PIN3_SEL, 32'h0);
    check({31'h0, err}, 32'h0);
    check(rd, {16'h0, sel[0]});
    results();
  end
endmodule : test_input_pin_signal_assignment
`default_nettype wire
